// ### hw/psc_frame_if.sv
// frame carrier between the serial slave and the command core
`default_nettype none
interface psc_frame_if;
	import psc_pkg::*;
	psc_frame_t rx_word;
	logic rx_valid;
	psc_frame_t tx_word;
	modport slave (output rx_word, output rx_valid, input tx_word);
	modport core (input rx_word, input rx_valid, output tx_word);
endinterface
`default_nettype wire

// ### hw/psc_map.svh
// register map, field positions and reset values of the power-supply commands
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_CMD_PS_WR 8'h51
`define PSC_CMD_PS_RD 8'h91
`define PSC_CMD_ESR_WR 8'h42
`define PSC_CMD_ESR_RD 8'h82
`define PSC_CMD_LIN_WR 8'h50
`define PSC_CMD_LIN_RD 8'h90
`define PSC_HDR_WR 3'h1
`define PSC_HDR_RD 3'h2
`define PSC_HDR_ESR_WR 3'h2
`define PSC_HDR_TAIL 4'he
`define PSC_PARITY_BIT 12
`define PSC_FRAME_BITS 5'h10
`define PSC_PS_BOOST_GOOD 7
`define PSC_PS_FAULT 6
`define PSC_PS_SYNC 5
`define PSC_PS_BOOST 4
`define PSC_PS_BUCK 2
`define PSC_SEL_HI 1
`define PSC_SEL_LO 0
`define PSC_ESR_EN 0
`define PSC_LIN_REN 5
`define PSC_RXO_HI 4
`define PSC_RXO_LO 3
`define PSC_LSR_HI 1
`define PSC_LSR_LO 0
`define PSC_ADC_HI 9
`define PSC_ADC_LO 2
`define PSC_RST_SYNC 1'b0
`define PSC_RST_BOOST 1'b1
`define PSC_RST_BUCK 1'b1
`define PSC_RST_SEL 2'h2
`define PSC_RST_ESR 1'b0
`define PSC_RST_REN 1'b0
`define PSC_RST_RXO 2'h0
`define PSC_RST_LSR 2'h0
`define PSC_ASY_RST 7'h40
`define PSC_SEL_OFF 2'h0
`define PSC_SEL_CHG 2'h1
`define PSC_SEL_DIS 2'h2
`endif

// ### hw/psc_pkg.sv
// types shared by the power-supply command block
`default_nettype none
package psc_pkg;
	typedef logic [15:0] psc_frame_t;
	typedef logic [7:0] psc_byte_t;
endpackage
`default_nettype wire

// ### hw/psc_reserve_ctl.sv
// reserve charge and discharge switch drive with frame-synchronous ESR test
`default_nettype none
`include "psc_map.svh"
module psc_reserve_ctl
	import psc_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic [1:0] reserve_switch_sel_i,
	input wire logic reserve_test_active_i,
	input wire logic frame_tick_i,
	output logic charge_sw_on_o,
	output logic discharge_sw_on_o,
	output logic test_armed_o
);
	logic tick_q;
	logic armed_q;
	logic chg_q;
	logic dis_q;
	wire tick_fall = tick_q & ~frame_tick_i;
	wire armed_d = reserve_test_active_i & (armed_q | tick_fall);
	wire chg_d = ~armed_d & (reserve_switch_sel_i == `PSC_SEL_CHG);
	wire dis_d = armed_d | (reserve_switch_sel_i == `PSC_SEL_DIS);
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			tick_q <= 1'b0;
			armed_q <= 1'b0;
			chg_q <= 1'b0;
			dis_q <= 1'b0;
		end
		else if (ce_i)
		begin
			tick_q <= frame_tick_i;
			armed_q <= armed_d;
			chg_q <= chg_d;
			dis_q <= dis_d;
		end
	end
	assign charge_sw_on_o = chg_q;
	assign discharge_sw_on_o = dis_q;
	assign test_armed_o = armed_q;
endmodule
`default_nettype wire

// ### hw/psc_spi_slave.sv
// 16-bit serial slave, mode 0, pins synchronised to clock_i
`default_nettype none
`include "psc_map.svh"
module psc_spi_slave
	import psc_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	psc_frame_if.slave frame
);
	logic [2:0] meta_q;
	logic [2:0] pin_q;
	logic [1:0] last_q;
	logic [4:0] cnt_q;
	psc_frame_t rx_q;
	psc_frame_t tx_q;
	psc_frame_t word_q;
	logic valid_q;
	wire sclk_s = pin_q[2];
	wire cs_n_s = pin_q[1];
	wire sclk_rise = sclk_s & ~last_q[1];
	wire sclk_fall = ~sclk_s & last_q[1];
	wire cs_fall = ~cs_n_s & last_q[0];
	wire cs_rise = cs_n_s & ~last_q[0];
	wire cnt_full = (cnt_q == 5'h1f);
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			meta_q <= 3'h3;
			pin_q <= 3'h3;
			last_q <= 2'h1;
			cnt_q <= 5'h0;
			rx_q <= 16'h0000;
			tx_q <= 16'h0000;
			word_q <= 16'h0000;
			valid_q <= 1'b0;
		end
		else if (ce_i)
		begin
			meta_q <= {spi_sclk_i, spi_cs_n_i, spi_mosi_i};
			pin_q <= meta_q;
			last_q <= pin_q[2:1];
			valid_q <= cs_rise && (cnt_q == `PSC_FRAME_BITS);
			if (cs_rise)
				word_q <= rx_q;
			if (cs_fall)
			begin
				tx_q <= frame.tx_word;
				cnt_q <= 5'h0;
			end
			else if (!cs_n_s && sclk_rise)
			begin
				rx_q <= {rx_q[14:0], pin_q[0]};
				cnt_q <= cnt_full ? cnt_q : cnt_q + 5'h1;
			end
			else if (!cs_n_s && sclk_fall)
				tx_q <= {tx_q[14:0], 1'b0};
		end
	end
	assign spi_miso_o = tx_q[15];
	assign spi_miso_oe_o = ~cs_n_s;
	assign frame.rx_word = word_q;
	assign frame.rx_valid = valid_q;
endmodule
`default_nettype wire

// ### hw/psc_top.sv
// power-supply command registers behind the 16-bit serial port
//
// Functional notes
// - power command: write byte 0x51, read byte 0x91, data in low byte
// - power bits hold until rewritten or reset; answer shows present state
// - shutdown switches a supply off regardless of latched bit; answer shows it
// - switch fault flag clears on reset or write with switch field 00
// - sleep reset restores switch field only; other bits need internal reset
// - answer bit 7 high while boost above about 80 percent target
// - answer bit 6 high after charge or discharge switch fault
// - bit 5 sync supply, bit 4 boost, bit 2 buck; all echoed
// - switch field: 00 off, 01 charge, 10 discharge, 11 off
// - test command: write 0x42, read 0x82, enable in bit 0 echoed
// - enabled test opens charge, closes discharge at next tick falling edge
// - test enable stays set until written back to zero
// - test read returns bits 9:2 of latest reserve voltage sample
// - test enable resets to zero and drives the test active output
// - channel field picks satellite 1 to 4 for the receive pin
// - monitor bit low routes LIN receive, high routes satellite signal
// - LIN command: write 0x50, read 0x90, held until rewritten or reset
`default_nettype none
`include "psc_map.svh"
module psc_top
	import psc_pkg::*;
#(
	parameter int ADC_W = 10,
	parameter int SAT_N = 4
)
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic sleep_rst_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	input wire logic boost_above_thr_i,
	input wire logic boost_shutdown_i,
	input wire logic buck_shutdown_i,
	input wire logic sync_shutdown_i,
	input wire logic charge_sw_fault_i,
	input wire logic discharge_sw_fault_i,
	input wire logic frame_tick_i,
	input wire logic adc_valid_i,
	input wire logic [ADC_W-1:0] adc_data_i,
	input wire logic lin_rx_i,
	input wire logic [SAT_N-1:0] sat_manchester_i,
	output logic boost_on_o,
	output logic buck_on_o,
	output logic sync_supply_on_o,
	output logic charge_sw_on_o,
	output logic discharge_sw_on_o,
	output logic reserve_test_active_o,
	output logic rxd_o
);
	localparam int ASY_W = SAT_N + 7;

	function automatic psc_frame_t psc_answer(input logic [2:0] hdr, input psc_byte_t dat);
		psc_frame_t f;
		f = {hdr, 1'b0, `PSC_HDR_TAIL, dat};
		f[`PSC_PARITY_BIT] = ~(^f);
		return f;
	endfunction

	psc_frame_if frame_bus ();

	psc_spi_slave u_spi (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.spi_sclk_i(spi_sclk_i),
		.spi_cs_n_i(spi_cs_n_i),
		.spi_mosi_i(spi_mosi_i),
		.spi_miso_o(spi_miso_o),
		.spi_miso_oe_o(spi_miso_oe_o),
		.frame(frame_bus.slave)
	);

	// asynchronous status and monitor inputs, two flops each
	logic [ASY_W-1:0] asy_meta_q;
	logic [ASY_W-1:0] asy_q;
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			// receive line idles high, no false low after reset
			asy_meta_q <= {{SAT_N{1'b0}}, `PSC_ASY_RST};
			asy_q <= {{SAT_N{1'b0}}, `PSC_ASY_RST};
		end
		else if (ce_i)
		begin
			asy_meta_q <= {sat_manchester_i, lin_rx_i, discharge_sw_fault_i,
				charge_sw_fault_i, sync_shutdown_i, buck_shutdown_i,
				boost_shutdown_i, boost_above_thr_i};
			asy_q <= asy_meta_q;
		end
	end
	wire boost_good_s = asy_q[0];
	wire boost_sd_s = asy_q[1];
	wire buck_sd_s = asy_q[2];
	wire sync_sd_s = asy_q[3];
	wire sw_fault_s = asy_q[4] | asy_q[5];
	wire lin_rx_s = asy_q[6];
	wire [SAT_N-1:0] sat_s = asy_q[ASY_W-1:7];

	// command decode
	psc_byte_t cmd;
	psc_byte_t dat;
	assign cmd = frame_bus.rx_word[15:8];
	assign dat = frame_bus.rx_word[7:0];
	wire wr_ps = frame_bus.rx_valid && (cmd == `PSC_CMD_PS_WR);
	wire wr_esr = frame_bus.rx_valid && (cmd == `PSC_CMD_ESR_WR);
	wire wr_lin = frame_bus.rx_valid && (cmd == `PSC_CMD_LIN_WR);
	wire sel_off_wr = wr_ps && (dat[`PSC_SEL_HI:`PSC_SEL_LO] == `PSC_SEL_OFF);

	// power control bits
	logic sync_supply_q;
	logic boost_q;
	logic buck_q;
	logic [1:0] sel_q;
	logic fault_q;
	wire fault_d = sw_fault_s | (fault_q & ~sel_off_wr);
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			sync_supply_q <= `PSC_RST_SYNC;
			boost_q <= `PSC_RST_BOOST;
			buck_q <= `PSC_RST_BUCK;
			fault_q <= 1'b0;
		end
		else if (ce_i)
		begin
			fault_q <= fault_d;
			if (wr_ps)
			begin
				sync_supply_q <= dat[`PSC_PS_SYNC];
				boost_q <= dat[`PSC_PS_BOOST];
				buck_q <= dat[`PSC_PS_BUCK];
			end
		end
	end

	// switch field also returns to default on sleep reset
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			sel_q <= `PSC_RST_SEL;
		else if (ce_i && sleep_rst_i)
			sel_q <= `PSC_RST_SEL;
		else if (ce_i && wr_ps)
			sel_q <= dat[`PSC_SEL_HI:`PSC_SEL_LO];
	end

	// shutdown overrides latched enables
	wire sync_act = sync_supply_q & ~sync_sd_s;
	wire boost_act = boost_q & ~boost_sd_s;
	wire buck_act = buck_q & ~buck_sd_s;
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			sync_supply_on_o <= `PSC_RST_SYNC;
			boost_on_o <= `PSC_RST_BOOST;
			buck_on_o <= `PSC_RST_BUCK;
		end
		else if (ce_i)
		begin
			sync_supply_on_o <= sync_act;
			boost_on_o <= boost_act;
			buck_on_o <= buck_act;
		end
	end

	// reserve test enable and latest sample
	logic test_q;
	logic [ADC_W-1:0] adc_q;
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			test_q <= `PSC_RST_ESR;
			adc_q <= '0;
		end
		else if (ce_i)
		begin
			if (wr_esr)
				test_q <= dat[`PSC_ESR_EN];
			if (adc_valid_i)
				adc_q <= adc_data_i;
		end
	end
	assign reserve_test_active_o = test_q;

	logic test_armed;
	psc_reserve_ctl u_reserve (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.reserve_switch_sel_i(sel_q),
		.reserve_test_active_i(test_q),
		.frame_tick_i(frame_tick_i),
		.charge_sw_on_o(charge_sw_on_o),
		.discharge_sw_on_o(discharge_sw_on_o),
		.test_armed_o(test_armed)
	);

	// receive pin monitor configuration
	logic ren_q;
	logic [1:0] rxo_q;
	logic [1:0] lsr_q;
	logic rxd_q;
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			ren_q <= `PSC_RST_REN;
			rxo_q <= `PSC_RST_RXO;
			lsr_q <= `PSC_RST_LSR;
		end
		else if (ce_i && wr_lin)
		begin
			ren_q <= dat[`PSC_LIN_REN];
			rxo_q <= dat[`PSC_RXO_HI:`PSC_RXO_LO];
			lsr_q <= dat[`PSC_LSR_HI:`PSC_LSR_LO];
		end
	end
	wire rx_pick = ren_q ? sat_s[rxo_q] : lin_rx_s;
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			rxd_q <= 1'b1;
		else if (ce_i)
			rxd_q <= rx_pick;
	end
	assign rxd_o = rxd_q;

	// answer to the last frame, shifted out during the next one
	psc_byte_t last_cmd_q;
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			last_cmd_q <= 8'h00;
		else if (ce_i && frame_bus.rx_valid)
			last_cmd_q <= cmd;
	end
	psc_byte_t ps_stat;
	psc_byte_t lin_stat;
	psc_byte_t esr_wr_stat;
	psc_byte_t esr_rd_stat;
	assign ps_stat = {boost_good_s, fault_q, sync_act, boost_act, 1'b0, buck_act, sel_q};
	assign lin_stat = {2'h0, ren_q, rxo_q, 1'b0, lsr_q};
	assign esr_wr_stat = {7'h00, test_q};
	assign esr_rd_stat = adc_q[`PSC_ADC_HI:`PSC_ADC_LO];
	assign frame_bus.tx_word =
		(last_cmd_q == `PSC_CMD_PS_WR) ? psc_answer(`PSC_HDR_WR, ps_stat) :
		(last_cmd_q == `PSC_CMD_PS_RD) ? psc_answer(`PSC_HDR_RD, ps_stat) :
		(last_cmd_q == `PSC_CMD_ESR_WR) ? psc_answer(`PSC_HDR_ESR_WR, esr_wr_stat) :
		(last_cmd_q == `PSC_CMD_ESR_RD) ? psc_answer(`PSC_HDR_RD, esr_rd_stat) :
		(last_cmd_q == `PSC_CMD_LIN_WR) ? psc_answer(`PSC_HDR_WR, lin_stat) :
		(last_cmd_q == `PSC_CMD_LIN_RD) ? psc_answer(`PSC_HDR_RD, lin_stat) :
		16'h0000;

	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (srst_i);

	a_power_write_latch: assert property (
		ce_i && wr_ps |=> sync_supply_q == $past(dat[`PSC_PS_SYNC])
			&& boost_q == $past(dat[`PSC_PS_BOOST]) && buck_q == $past(dat[`PSC_PS_BUCK]))
		else $error("power write not latched");

	a_power_hold: assert property (
		!wr_ps |=> $stable(sync_supply_q) && $stable(boost_q) && $stable(buck_q))
		else $error("power bits changed without write");

	a_shutdown_gate: assert property (
		ce_i && boost_sd_s |-> !ps_stat[`PSC_PS_BOOST] ##1 !boost_on_o)
		else $error("boost on during shutdown");

	a_buck_gate: assert property (
		ce_i && buck_sd_s |-> !ps_stat[`PSC_PS_BUCK] ##1 !buck_on_o)
		else $error("buck on during shutdown");

	a_sync_gate: assert property (
		ce_i && sync_sd_s |-> !ps_stat[`PSC_PS_SYNC] ##1 !sync_supply_on_o)
		else $error("sync supply on during shutdown");

	a_fault_set: assert property (
		ce_i && sw_fault_s |=> fault_q)
		else $error("switch fault not flagged");

	a_fault_clear: assert property (
		ce_i && sel_off_wr && !sw_fault_s |=> !fault_q)
		else $error("switch fault not cleared by off write");

	a_sleep_sel: assert property (
		ce_i && sleep_rst_i |=> sel_q == `PSC_RST_SEL && ($stable(boost_q) || $past(wr_ps)))
		else $error("sleep reset handling wrong");

	a_reserve_decode: assert property (
		ce_i && !test_q && sel_q == `PSC_SEL_CHG |=> charge_sw_on_o && !discharge_sw_on_o)
		else $error("charge selection not applied");

	a_esr_switches: assert property (
		ce_i && test_armed && test_q |=> discharge_sw_on_o && !charge_sw_on_o)
		else $error("test did not swap switches");

	a_esr_hold: assert property (
		test_q && !wr_esr |=> test_q)
		else $error("test enable dropped");

	a_esr_read_data: assert property (
		ce_i && adc_valid_i ##1 last_cmd_q == `PSC_CMD_ESR_RD
			|-> frame_bus.tx_word[7:0] == $past(adc_data_i[`PSC_ADC_HI:`PSC_ADC_LO]))
		else $error("test read data wrong");

	a_rx_lin_route: assert property (
		ce_i && !ren_q |=> rxd_o == $past(lin_rx_s))
		else $error("receive pin not carrying lin signal");

	a_rx_sat_route: assert property (
		ce_i && ren_q |=> rxd_o == $past(sat_s[rxo_q]))
		else $error("receive pin not carrying selected satellite");

	a_test_output: assert property (
		ce_i && wr_esr |=> reserve_test_active_o == $past(dat[`PSC_ESR_EN]))
		else $error("test active output not following enable");

	a_adc_capture: assert property (
		ce_i && adc_valid_i |=> adc_q[`PSC_ADC_HI:`PSC_ADC_LO]
			== $past(adc_data_i[`PSC_ADC_HI:`PSC_ADC_LO]))
		else $error("sample not captured");

	a_answer_parity: assert property (
		last_cmd_q == `PSC_CMD_PS_WR |-> ^frame_bus.tx_word)
		else $error("answer parity not odd");

	a_esr_echo: assert property (
		last_cmd_q == `PSC_CMD_ESR_WR |-> frame_bus.tx_word[7:0] == {7'h00, test_q})
		else $error("test enable echo wrong");

	a_boost_good_bit: assert property (
		last_cmd_q == `PSC_CMD_PS_RD |-> frame_bus.tx_word[`PSC_PS_BOOST_GOOD] == boost_good_s
			&& frame_bus.tx_word[3] == 1'b0)
		else $error("power answer bits wrong");

	c_power_write: cover property (ce_i && wr_ps);
	c_esr_armed: cover property (ce_i && test_armed ##1 discharge_sw_on_o);
	c_sleep_reset: cover property (ce_i && sleep_rst_i && sel_q != `PSC_RST_SEL);
	c_fault_flag: cover property (ce_i && sw_fault_s ##1 fault_q);
	c_rx_monitor: cover property (ce_i && ren_q && rxo_q == 2'h3);
endmodule
`default_nettype wire

// ### testbench/power_supply_spi_control_test.sv
// self-checking bench of the power-supply command block
`default_nettype none
`include "psc_map.svh"
module power_supply_spi_control_test
	import psc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic sleep_rst_i = 1'b0;
	logic ce = 1'b1;
	logic sclk, cs_n, mosi, miso, miso_oe;
	logic bst_thr = 1'b0;
	logic b_sd = 1'b0;
	logic k_sd = 1'b0;
	logic s_sd = 1'b0;
	logic c_flt = 1'b0;
	logic d_flt = 1'b0;
	logic tick = 1'b0;
	logic adc_v = 1'b0;
	logic [9:0] adc_d = 10'h000;
	logic lin_rx = 1'b1;
	logic [3:0] sat = 4'h0;
	logic boost_on, buck_on, sync_on, chg_on, dis_on, test_act, rxd;
	logic [7:0] r = 8'h51;
	int num_errors = 0;
	int tests_run = 0;
	int m_sync = 0, m_boost = 1, m_buck = 1, m_sel = 2, m_flt = 0;
	int m_en = 0, m_arm = 0, m_adc = 0, m_ren = 0, m_rxo = 0, m_lsr = 0;
	psc_frame_t prev = 16'h0000;
	bit have_prev = 0;
	always #5 clock_i = ~clock_i;
	psc_host_model host_u (.clock_i(clock_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
		.mosi_o(mosi));
	psc_top dut_u (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce), .sleep_rst_i(sleep_rst_i),
		.spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
		.spi_miso_oe_o(miso_oe), .boost_above_thr_i(bst_thr), .boost_shutdown_i(b_sd),
		.buck_shutdown_i(k_sd), .sync_shutdown_i(s_sd), .charge_sw_fault_i(c_flt),
		.discharge_sw_fault_i(d_flt), .frame_tick_i(tick), .adc_valid_i(adc_v),
		.adc_data_i(adc_d), .lin_rx_i(lin_rx), .sat_manchester_i(sat),
		.boost_on_o(boost_on), .buck_on_o(buck_on), .sync_supply_on_o(sync_on),
		.charge_sw_on_o(chg_on), .discharge_sw_on_o(dis_on),
		.reserve_test_active_o(test_act), .rxd_o(rxd));
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
		tests_run++;
		if (s !== x)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	// expected answer, odd parity over the whole word
	function automatic psc_frame_t answer(input psc_frame_t c);
		logic [2:0] h;
		psc_byte_t d;
		case (c[15:8])
			`PSC_CMD_PS_WR, `PSC_CMD_LIN_WR: h = 3'h1;
			`PSC_CMD_PS_RD, `PSC_CMD_ESR_WR, `PSC_CMD_ESR_RD, `PSC_CMD_LIN_RD: h = 3'h2;
			default: return 16'h0000;
		endcase
		if (c[12:8] == 5'h11)
			d = {bst_thr, m_flt[0], m_sync[0] & ~s_sd, m_boost[0] & ~b_sd, 1'b0,
				m_buck[0] & ~k_sd, m_sel[1:0]};
		else if (c[15:8] == `PSC_CMD_ESR_WR)
			d = {7'h00, m_en[0]};
		else if (c[15:8] == `PSC_CMD_ESR_RD)
			d = m_adc[9:2];
		else
			d = {2'h0, m_ren[0], m_rxo[1:0], 1'b0, m_lsr[1:0]};
		return {h, ~^{h, 4'he, d}, 4'he, d};
	endfunction
	task automatic apply(input psc_frame_t c);
		if (c[15:8] == `PSC_CMD_PS_WR)
		begin
			m_sync = c[5];
			m_boost = c[4];
			m_buck = c[2];
			m_sel = c[1:0];
			if (c[1:0] == 2'h0)
				m_flt = 0;
		end
		if (c[15:8] == `PSC_CMD_ESR_WR)
		begin
			m_en = c[0];
			if (!c[0])
				m_arm = 0;
		end
		if (c[15:8] == `PSC_CMD_LIN_WR)
		begin
			m_ren = c[5];
			m_rxo = c[4:3];
			m_lsr = c[1:0];
		end
	endtask
	// answer of a frame shows in the next one
	task automatic frame(input psc_frame_t c);
		psc_frame_t e, g;
		e = answer(prev);
		fork
			host_u.xfer(c, g);
			begin
				repeat (20) @(negedge clock_i);
				check("miso_oe", miso_oe, 1'b1);
			end
		join
		if (have_prev)
			check("answer", g, e);
		apply(c);
		prev = c;
		have_prev = 1;
	endtask
	task automatic check_outs();
		repeat (5) @(negedge clock_i);
		check("miso_oe", miso_oe, 1'b0);
		check("boost", boost_on, m_boost[0] & ~b_sd);
		check("buck", buck_on, m_buck[0] & ~k_sd);
		check("sync", sync_on, m_sync[0] & ~s_sd);
		check("charge", chg_on, m_arm == 0 && m_sel == 1);
		check("discharge", dis_on, m_arm != 0 || m_sel == 2);
		check("test", test_act, m_en[0]);
		check("rxd", rxd, m_ren[0] ? sat[m_rxo] : lin_rx);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clock_i);
		num_errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (8) @(negedge clock_i);
		srst_i = 1'b0;
		check_outs();
		frame(16'h9100);
		frame(16'h9000);
		done("reset");
		for (int i = 0; i < 4; i++)
		begin
			r = lfsr_next(r);
			bst_thr = r[0];
			frame({`PSC_CMD_PS_WR, r[7:2], i[1:0]});
			check_outs();
		end
		frame(16'h9100);
		done("power");
		frame(16'h5135);
		{b_sd, k_sd, s_sd} = 3'b101;
		check_outs();
		frame(16'h9100);
		{b_sd, k_sd, s_sd} = 3'b010;
		check_outs();
		frame(16'h9100);
		{b_sd, k_sd, s_sd} = 3'b000;
		done("shutdown");
		ce = 1'b0;
		b_sd = 1'b1;
		repeat (6) @(negedge clock_i);
		check("frozen", {boost_on, buck_on}, {m_boost[0], 1'b0});
		ce = 1'b1;
		check_outs();
		b_sd = 1'b0;
		done("enable");
		for (int i = 0; i < 2; i++)
		begin
			{c_flt, d_flt} = i[0] ? 2'b01 : 2'b10;
			m_flt = 1;
			repeat (6) @(negedge clock_i);
			{c_flt, d_flt} = 2'b00;
			frame(16'h5131);
			frame(16'h5130);
			frame(16'h9100);
		end
		done("fault");
		frame(16'h5121);
		sleep_rst_i = 1'b1;
		@(negedge clock_i);
		sleep_rst_i = 1'b0;
		m_sel = 2;
		check_outs();
		frame(16'h9100);
		frame(16'h9100);
		done("sleep");
		frame(16'h5131);
		r = lfsr_next(r);
		adc_d = {r, r[7:6]};
		adc_v = 1'b1;
		@(negedge clock_i);
		adc_v = 1'b0;
		m_adc = adc_d;
		frame(16'h42fd);
		check_outs();
		for (int i = 0; i < 2; i++)
		begin
			tick = 1'b1;
			repeat (3) @(negedge clock_i);
			tick = 1'b0;
			m_arm = 1;
			check_outs();
		end
		frame(16'h8200);
		r = lfsr_next(r);
		adc_d = {r[1:0], r};
		adc_v = 1'b1;
		@(negedge clock_i);
		adc_v = 1'b0;
		m_adc = adc_d;
		frame(16'h4200);
		check_outs();
		frame(16'h9100);
		done("reserve test");
		for (int i = 0; i < 4; i++)
		begin
			r = lfsr_next(r);
			sat = r[3:0];
			frame({`PSC_CMD_LIN_WR, r[7:6], 1'b1, i[1:0], r[2:0]});
			check_outs();
		end
		lin_rx = 1'b0;
		frame(16'h50c4);
		check_outs();
		frame(16'h9000);
		done("receive pin");
		host_u.half = 5;
		frame(16'h7700);
		frame(16'h9100);
		host_u.half = 9;
		frame(16'h9100);
		frame(16'h9000);
		done("unknown and timing");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ### testbench/psc_host_model.sv
// host model: mode 0 master sending 16-bit frames
`default_nettype none
module psc_host_model
	import psc_pkg::*;
(
	input wire logic clock_i,
	input wire logic miso_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// clocks per serial clock phase, set by the bench
	int half = 6;
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	// command byte high, data low, msb first; answer taken before each rise
	task automatic xfer(input psc_frame_t cmd, output psc_frame_t ans);
		cs_n_o = 1'b0;
		wait_n(half);
		for (int i = 15; i >= 0; i--)
		begin
			mosi_o = cmd[i];
			wait_n(half);
			ans[i] = miso_i;
			sclk_o = 1'b1;
			wait_n(half);
			sclk_o = 1'b0;
		end
		wait_n(half);
		cs_n_o = 1'b1;
		// released line must not keep the last bit
		mosi_o = ~mosi_o;
		wait_n(8);
	endtask
endmodule
`default_nettype wire
